/* File: pkg/pmc_defs.vh */
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMC_ADDR_W 8
`define PMC_OFF_TX_CFG 8'h30
`define PMC_OFF_TX_MASK 8'h4a
`define PMC_OFF_LCV_HI 8'h50
`define PMC_OFF_LCV_LO 8'h51
`define PMC_OFF_FRM_HI 8'h52
`define PMC_OFF_FRM_LO 8'h53
`define PMC_OFF_PAR_HI 8'h54
`define PMC_OFF_PAR_LO 8'h55
`define PMC_OFF_FEB_HI 8'h56
`define PMC_OFF_FEB_LO 8'h57
`define PMC_OFF_HOLD 8'h6c
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PMC_TX_INS_EN_BIT 7
`define PMC_MASK_RST 4'h0
`define PMC_CFG_RST 8'h00
`define PMC_CNT_RST 16'h0000
`define PMC_HOLD_RST 8'h00
// ----------------------------------------
// Framing format codes
// ----------------------------------------
`define PMC_FMT_DS3_CBIT 2'h0
`define PMC_FMT_DS3_M13 2'h1
`define PMC_FMT_E3_G751 2'h2
`define PMC_FMT_E3_G832 2'h3
`endif

/* File: rtl/pmc_event_counter.v */
`timescale 1ns/100ps
`include "pmc_defs.vh"
// One 16-bit clear-on-read event counter
module pmc_event_counter (
   input wire clk,
   input wire srst,
   input wire eventIn,
   input wire clearIn,
   output wire [15:0] count
);
   reg [15:0] countQ;
   reg [15:0] countD;
   // Clear wins over the old value, but an event in the clear cycle becomes count one
   always @* begin
      countD = countQ;
      if (clearIn) begin
         countD = eventIn ? 16'h0001 : `PMC_CNT_RST; // RQ11
      end else if (eventIn && (countQ != 16'hffff)) begin
         countD = countQ + 16'h0001; // Saturate rather than wrap
      end
   end
   // Counter store
   always @(posedge clk) begin
      if (srst) begin
         countQ <= `PMC_CNT_RST; // RQ8
      end else begin
         countQ <= countD;
      end
   end
   assign count = countQ;
endmodule // pmc_event_counter

/* File: rtl/pmc_bip_inject.v */
`timescale 1ns/100ps
`include "pmc_defs.vh"
// Registered BIP-4 nibble error injection
module pmc_bip_inject (
   input wire clk,
   input wire srst,
   input wire [3:0] bipIn,
   input wire bipValid,
   input wire [3:0] maskIn,
   input wire insertEnable,
   output wire [3:0] bipOut,
   output wire bipOutValid
);
   reg [3:0] bipOutQ;
   reg validQ;
   // Mask applies only while insertion is enabled
   always @(posedge clk) begin
      if (srst) begin
         bipOutQ <= 4'h0;
         validQ <= 1'b0;
      end else begin
         validQ <= bipValid;
         if (bipValid) begin
            bipOutQ <= insertEnable ? (bipIn ^ maskIn) : bipIn; // RQ1 RQ3
         end
      end
   end
   assign bipOut = bipOutQ;
   assign bipOutValid = validQ;
endmodule // pmc_bip_inject

/* File: rtl/pmc_perf_monitor.v */
`timescale 1ns/100ps
`include "pmc_defs.vh"
// Summary of operation
// RQ1 - Outgoing BIP-4 nibble is computed nibble XOR transmit parity mask.
// RQ2 - Mask resets to zero; zero mask sends BIP-4 unchanged.
// RQ3 - Mask ignored while insert enable, bit 7 of register 0x30, is zero.
// RQ4 - Sixteen-bit count of line code violations since last read.
// RQ5 - Sixteen-bit count of framing bit or byte errors since last read.
// RQ6 - Parity count takes P-bit, BIP-4 or BIP-8 errors by framing format.
// RQ7 - Sixteen-bit count of far-end block errors since last read.
// RQ8 - Reading a counter byte returns it and clears it; all reset zero.
// RQ9 - Each counter: upper byte at even address, lower byte at next.
// RQ10 - First read clears whole counter; other byte waits in holding register 0x6c.
// RQ11 - Event in the clearing cycle counts as first of new interval.
module pmc_perf_monitor (
   input wire clk,
   input wire srst,
   input wire [7:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrEn,
   input wire regRdEn,
   output reg [7:0] regRdData,
   input wire [1:0] framingFormat,
   input wire lineCodeViolationIn,
   input wire framingErrorIn,
   input wire pbitErrorIn,
   input wire bip4ErrorIn,
   input wire bip8ErrorIn,
   input wire farEndBlockErrorIn,
   input wire [3:0] txBipNibble,
   input wire txBipValid,
   output reg [3:0] txBipNibbleOut,
   output reg txBipNibbleOutValid
);
   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Counter index for an address in 0x50..0x57, valid flag in bit 2
   function [2:0] cntSel;
      input [7:0] a;
      begin
         cntSel = {(a[7:3] == 5'h0a), a[2:1]};
      end
   endfunction

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   reg [7:0] txCfg_q;
   reg [3:0] txMask_q;
   // Host writes; unmapped writes are dropped
   always @(posedge clk) begin
      if (srst) begin
         txCfg_q <= `PMC_CFG_RST;
         txMask_q <= `PMC_MASK_RST; // RQ2
      end else if (regWrEn) begin
         if (regAddr == `PMC_OFF_TX_CFG) begin
            txCfg_q <= regWrData;
         end
         if (regAddr == `PMC_OFF_TX_MASK) begin
            txMask_q <= regWrData[3:0];
         end
      end
   end

   // ----------------------------------------
   // Event selection
   // ----------------------------------------
   reg parityEvent;
   // Only the error type of the active format reaches the parity counter
   always @* begin
      case (framingFormat)
         `PMC_FMT_E3_G751: parityEvent = bip4ErrorIn; // RQ6
         `PMC_FMT_E3_G832: parityEvent = bip8ErrorIn; // RQ6
         default: parityEvent = pbitErrorIn; // RQ6
      endcase
   end
   wire [3:0] events;
   assign events = {farEndBlockErrorIn, parityEvent, framingErrorIn, lineCodeViolationIn};

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   wire [2:0] rdSel;
   assign rdSel = cntSel(regAddr);
   wire rdCounter;
   assign rdCounter = regRdEn && rdSel[2];
   wire [63:0] countsFlat;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : gCnt
         // Either byte read clears the whole counter
         pmc_event_counter uCnt (
            .clk(clk),
            .srst(srst),
            .eventIn(events[gi]), // RQ4 RQ5 RQ7
            .clearIn(rdCounter && (rdSel[1:0] == gi)), // RQ8 RQ10
            .count(countsFlat[gi*16 +: 16])
         );
      end
   endgenerate
   wire [15:0] selCount;
   assign selCount = countsFlat[rdSel[1:0]*16 +: 16];

   // ----------------------------------------
   // Holding register and read data
   // ----------------------------------------
   reg [7:0] hold_q;
   reg [7:0] rdData_d;
   reg [7:0] hold_d;
   // Reading the holding register consumes it; it is clear-on-read too
   always @* begin
      rdData_d = 8'h00;
      hold_d = hold_q;
      if (regRdEn) begin
         if (rdSel[2]) begin
            if (regAddr[0] == 1'b0) begin
               rdData_d = selCount[15:8]; // RQ9
               hold_d = selCount[7:0]; // RQ10
            end else begin
               rdData_d = selCount[7:0]; // RQ9
               hold_d = selCount[15:8]; // RQ10
            end
         end else begin
            case (regAddr)
               `PMC_OFF_TX_CFG: rdData_d = txCfg_q;
               `PMC_OFF_TX_MASK: rdData_d = {4'h0, txMask_q};
               `PMC_OFF_HOLD: begin
                  rdData_d = hold_q;
                  hold_d = `PMC_HOLD_RST;
               end
               default: rdData_d = 8'h00; // Unmapped reads return zero
            endcase
         end
      end
   end
   // Read data registered; held until the next read
   always @(posedge clk) begin
      if (srst) begin
         hold_q <= `PMC_HOLD_RST;
         regRdData <= 8'h00;
      end else begin
         hold_q <= hold_d;
         if (regRdEn) begin
            regRdData <= rdData_d;
         end
      end
   end

   // ----------------------------------------
   // Transmit BIP-4 injection
   // ----------------------------------------
   wire [3:0] injNibble;
   wire injValid;
   pmc_bip_inject uInj (
      .clk(clk),
      .srst(srst),
      .bipIn(txBipNibble),
      .bipValid(txBipValid),
      .maskIn(txMask_q), // RQ1
      .insertEnable(txCfg_q[`PMC_TX_INS_EN_BIT]), // RQ3
      .bipOut(injNibble),
      .bipOutValid(injValid)
   );
   // Extra stage keeps outputs straight from flops
   always @(posedge clk) begin
      if (srst) begin
         txBipNibbleOut <= 4'h0;
         txBipNibbleOutValid <= 1'b0;
      end else begin
         txBipNibbleOut <= injNibble;
         txBipNibbleOutValid <= injValid;
      end
   end
endmodule // pmc_perf_monitor

/* File: dv/pmc_perf_monitor_monitor.sv */
`timescale 1ns/100ps
`include "pmc_defs.vh"
// Register bus and tx nibble checks
module pmc_checker (
   input wire clk,
   input wire srst,
   input wire [7:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrEn,
   input wire regRdEn,
   input wire [7:0] regRdData,
   input wire lineCodeViolationIn,
   input wire [3:0] txBipNibble,
   input wire txBipValid,
   input wire [3:0] txBipNibbleOut,
   input wire txBipNibbleOutValid
);
   reg enQ;
   reg [3:0] maskQ;
   wire [3:0] expNib = txBipNibble ^ (enQ ? maskQ : 4'h0);
   wire rdHi = regRdEn && regAddr == `PMC_OFF_LCV_HI;
   // Shadow of insert enable and mask, written only through the bus
   always @(posedge clk) begin
      if (srst) begin
         enQ <= 1'b0;
         maskQ <= 4'h0;
      end else if (regWrEn) begin
         if (regAddr == `PMC_OFF_TX_CFG) enQ <= regWrData[`PMC_TX_INS_EN_BIT];
         if (regAddr == `PMC_OFF_TX_MASK) maskQ <= regWrData[3:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   chk_tx_nibble: assert property (txBipValid |-> ##2 txBipNibbleOut == $past(expNib, 2))
      else $error("tx nibble wrong");
   chk_tx_latency: assert property (txBipValid |-> ##2 txBipNibbleOutValid)
      else $error("tx valid late");
   chk_mask_read: assert property (regRdEn && regAddr == `PMC_OFF_TX_MASK |=> regRdData == {4'h0, maskQ})
      else $error("mask readback wrong");
   chk_read_stands: assert property (!regRdEn |=> $stable(regRdData))
      else $error("read data moved");
   chk_clear_read: assert property (rdHi && !lineCodeViolationIn ##1 rdHi |=> regRdData == 8'h00)
      else $error("counter not cleared");
   chk_clear_event: assert property (rdHi && lineCodeViolationIn ##1 regRdEn && regAddr == `PMC_OFF_LCV_LO
      |=> regRdData == 8'h01)
      else $error("event lost on clear");
   chk_hold_clear: assert property (regRdEn && regAddr == `PMC_OFF_HOLD ##1 regRdEn && regAddr == `PMC_OFF_HOLD
      |=> regRdData == 8'h00)
      else $error("hold not cleared");
   chk_unmapped_zero: assert property (regRdEn && regAddr == 8'h7f |=> regRdData == 8'h00)
      else $error("unmapped read nonzero");
endmodule // pmc_checker
bind pmc_perf_monitor pmc_checker u_pmc_checker (.clk(clk), .srst(srst), .regAddr(regAddr),
   .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
   .lineCodeViolationIn(lineCodeViolationIn), .txBipNibble(txBipNibble), .txBipValid(txBipValid),
   .txBipNibbleOut(txBipNibbleOut), .txBipNibbleOutValid(txBipNibbleOutValid));

/* File: dv/pmc_host_model.sv */
`timescale 1ns/100ps
`include "pmc_defs.vh"
// Host processor on the byte-wide register bus
module pmc_host_model (
   input wire clk,
   output reg [7:0] regAddr = 8'h00,
   output reg [7:0] regWrData = 8'h00,
   output reg regWrEn = 1'b0,
   output reg regRdEn = 1'b0,
   input wire [7:0] regRdData
);
   // Data inverted after a write so nothing stale looks valid
   task wr(input [7:0] a, input [7:0] d);
      begin
         regAddr = a;
         regWrData = d;
         regWrEn = 1'b1;
         @(negedge clk);
         regWrEn = 1'b0;
         regWrData = ~d;
         @(negedge clk);
      end
   endtask
   // Strobe stays high so reads may run back to back
   task rd(input [7:0] a, output [7:0] d);
      begin
         regAddr = a;
         regRdEn = 1'b1;
         @(negedge clk);
         d = regRdData;
      end
   endtask
   task idle;
      begin
         regRdEn = 1'b0;
         @(negedge clk);
      end
   endtask
   // Either byte first, the other from the holding byte
   task rd16(input [7:0] a, output [15:0] v);
      reg [7:0] b1;
      reg [7:0] b2;
      begin
         rd(a, b1);
         rd(`PMC_OFF_HOLD, b2);
         idle;
         v = a[0] ? {b2, b1} : {b1, b2};
      end
   endtask
endmodule // pmc_host_model

/* File: dv/pmc_perf_monitor_test.sv */
`timescale 1ns/100ps
`include "pmc_defs.vh"
module pmc_perf_monitor_test;
   reg clk = 1'b0;
   reg srst = 1'b1;
   reg [1:0] fmt = 2'h0;
   reg [5:0] ev = 6'h00;
   reg [3:0] nib = 4'h0;
   reg txv = 1'b0;
   reg [31:0] seed = 32'hf40b;
   reg [15:0] cnt [0:3];
   reg [15:0] v;
   reg [7:0] b;
   wire [7:0] regAddr, regWrData, regRdData;
   wire regWrEn, regRdEn, txOutValid;
   wire [3:0] txOut;
   integer numErrors = 0, checkCount = 0, i, k;
   always #10 clk = ~clk;
   pmc_perf_monitor u_pmc_perf_monitor (.clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .framingFormat(fmt),
      .lineCodeViolationIn(ev[0]), .framingErrorIn(ev[1]), .pbitErrorIn(ev[2]), .bip4ErrorIn(ev[3]),
      .bip8ErrorIn(ev[4]), .farEndBlockErrorIn(ev[5]), .txBipNibble(nib), .txBipValid(txv),
      .txBipNibbleOut(txOut), .txBipNibbleOutValid(txOutValid));
   pmc_host_model u_pmc_host_model (.clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData));
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // Parity source follows the framing format
   function par(input [1:0] f, input [5:0] e);
      par = f == `PMC_FMT_E3_G832 ? e[4] : f == `PMC_FMT_E3_G751 ? e[3] : e[2];
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checkCount = checkCount + 1;
         if (got !== exp) begin
            numErrors = numErrors + 1;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task finalReport;
      begin
         $display("checks=%0d errors=%0d", checkCount, numErrors);
         if (numErrors == 0 && checkCount > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // Watchdog, far beyond the expected run
   initial begin
      #400000;
      numErrors = numErrors + 1;
      finalReport;
   end
   initial begin
      repeat (2) @(negedge clk);
      srst = 1'b0;
      // Reset values, then an unmapped byte
      for (i = 0; i < 10; i = i + 1) begin
         u_pmc_host_model.rd(i < 8 ? 8'h50 + i[7:0] : i == 8 ? `PMC_OFF_TX_MASK : 8'h7f, b);
         chk({8'h00, b}, 16'h0000);
      end
      u_pmc_host_model.idle;
      // Random events in every framing format
      for (k = 0; k < 4; k = k + 1) begin
         fmt = k[1:0];
         for (i = 0; i < 4; i = i + 1) cnt[i] = 16'h0000;
         for (i = 0; i < 150; i = i + 1) begin
            seed = xs(seed);
            ev = seed[5:0];
            cnt[0] = cnt[0] + ev[0];
            cnt[1] = cnt[1] + ev[1];
            cnt[2] = cnt[2] + par(fmt, ev);
            cnt[3] = cnt[3] + ev[5];
            @(negedge clk);
         end
         ev = 6'h00;
         for (i = 0; i < 4; i = i + 1) begin
            u_pmc_host_model.rd16(8'h50 + 2 * i[7:0] + seed[i], v);
            chk(v, cnt[i]);
         end
      end
      // Event on the clearing read, then back-to-back reads
      ev = 6'h01;
      u_pmc_host_model.rd(`PMC_OFF_LCV_HI, b);
      ev = 6'h00;
      u_pmc_host_model.rd(`PMC_OFF_LCV_LO, b);
      chk({8'h00, b}, 16'h0001);
      u_pmc_host_model.rd(`PMC_OFF_LCV_HI, b);
      u_pmc_host_model.rd(`PMC_OFF_LCV_HI, b);
      chk({8'h00, b}, 16'h0000);
      // One event with the strobe low, so the holding byte is non-zero
      ev = 6'h01;
      u_pmc_host_model.idle;
      ev = 6'h00;
      u_pmc_host_model.rd(`PMC_OFF_LCV_HI, b);
      chk({8'h00, b}, 16'h0000);
      u_pmc_host_model.rd(`PMC_OFF_HOLD, b);
      chk({8'h00, b}, 16'h0001);
      u_pmc_host_model.rd(`PMC_OFF_HOLD, b);
      chk({8'h00, b}, 16'h0000);
      u_pmc_host_model.idle;
      // Injection off, zero mask, masked but disabled, live injection
      for (i = 0; i < 4; i = i + 1) begin
         seed = xs(seed);
         u_pmc_host_model.wr(`PMC_OFF_TX_CFG, {i[0], 7'h00});
         u_pmc_host_model.wr(`PMC_OFF_TX_MASK, i[1] ? seed[7:0] : 8'h00);
         u_pmc_host_model.rd(`PMC_OFF_TX_MASK, b);
         chk({8'h00, b}, {12'h000, i[1] ? seed[3:0] : 4'h0});
         u_pmc_host_model.idle;
         nib = seed[11:8];
         txv = 1'b1;
         @(negedge clk);
         txv = 1'b0;
         @(negedge clk);
         chk({txOutValid, 11'h000, txOut}, {1'b1, 11'h000, nib ^ (i == 3 ? seed[3:0] : 4'h0)});
      end
      finalReport;
   end
endmodule // pmc_perf_monitor_test
